/* File: logic/macrocell_pkg.sv */
// shared constants and types for the output macrocell block
package macrocell_pkg;
   // =====================================================
   // geometry
   localparam int NUM_CELLS = 10;
   localparam int NUM_DED_IN = 12;
   localparam int MIN_TERMS = 8;
   localparam int MAX_TERMS = 16;
   // =====================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CFG_TYPE = 8'h00;
   localparam logic [7:0] ADDR_CFG_POL = 8'h04;
   localparam logic [7:0] ADDR_CFG_FB = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0c;
   localparam logic [7:0] ADDR_PRELOAD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_READBACK = 8'h18;
   // ctrl fields
   localparam int CTRL_SECURE_BIT = 0;
   localparam int CTRL_VARIANT_BIT = 1;
   // reset values
   localparam logic [9:0] CFG_RST = 10'h000;
   localparam logic [9:0] CELL_RST = 10'h000;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =====================================================
   // per-cell configuration bundle
   typedef struct packed {
      logic [9:0] type_sel;  // output_type_select, 1 = combinatorial
      logic [9:0] pol_sel;   // output_polarity_select, 1 = active high
      logic [9:0] fb_sel;    // feedback_source_select
   } cell_cfg_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_RESP = 2'b01
   } rd_state_t;
endpackage : macrocell_pkg

/* File: logic/output_macrocell.sv */
// ten-cell programmable output macrocell stage with an AXI4-Lite config port
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module output_macrocell #(
   parameter int NCELL = 10
) (
   input wire logic CLK_SYS, // system clock
   input wire logic RST, // synchronous reset, high
   input wire logic [11:0] DED_IN, // dedicated inputs
   input wire logic [NCELL*16-1:0] PTERM, // product terms, 16 slots per cell
   input wire logic [NCELL-1:0] OE_TERM, // per-pin output enable terms
   input wire logic PRESET_TERM, // shared synchronous preset
   input wire logic ARESET_TERM, // shared asynchronous reset
   input wire logic [NCELL-1:0] PIN_I, // pin input level
   output logic [NCELL-1:0] PIN_O, // pin drive value
   output logic [NCELL-1:0] PIN_OE_N, // pin drive enable, low drives
   output logic [NCELL+11:0] ARRAY_IN, // inputs seen by the array
   output logic [NCELL-1:0] FEEDBACK, // per-cell array feedback
   input wire logic [7:0] S_AXI_AWADDR, // write address
   input wire logic S_AXI_AWVALID, // write address valid
   output logic S_AXI_AWREADY, // write address ready
   input wire logic [31:0] S_AXI_WDATA, // write data
   input wire logic [3:0] S_AXI_WSTRB, // write strobes
   input wire logic S_AXI_WVALID, // write data valid
   output logic S_AXI_WREADY, // write data ready
   output logic [1:0] S_AXI_BRESP, // write response
   output logic S_AXI_BVALID, // write response valid
   input wire logic S_AXI_BREADY, // write response ready
   input wire logic [7:0] S_AXI_ARADDR, // read address
   input wire logic S_AXI_ARVALID, // read address valid
   output logic S_AXI_ARREADY, // read address ready
   output logic [31:0] S_AXI_RDATA, // read data
   output logic [1:0] S_AXI_RRESP, // read response
   output logic S_AXI_RVALID, // read valid
   input wire logic S_AXI_RREADY // read ready
);
   // =====================================================
   // configuration state
   macrocell_pkg::cell_cfg_t cfg_r;
   logic secure_r;
   logic variant_r;
   logic [NCELL-1:0] cell_r;
   logic [NCELL-1:0] sum_term;
   logic [NCELL-1:0] out_val;
   logic [NCELL-1:0] preload_val_r;
   logic preload_req_r;
   logic areset_seen_r;
   // fixed term count per cell: 8,10,12,14,16,16,14,12,10,8
   function automatic int terms_of(input int idx);
      int k;
      k = (idx < NCELL / 2) ? idx : (NCELL - 1 - idx);
      terms_of = macrocell_pkg::MIN_TERMS + 2 * k;
      if (terms_of > macrocell_pkg::MAX_TERMS) begin
         terms_of = macrocell_pkg::MAX_TERMS;
      end
   endfunction : terms_of

   // =====================================================
   // per-cell datapath
   genvar g;
   generate
      for (g = 0; g < NCELL; g++) begin : g_cell
         localparam int NT = terms_of(g);
         // only the allotted slots join the sum, the rest are unused
         assign sum_term[g] = |PTERM[g*16 +: NT];
         // register value or sum term picked by type bit
         assign out_val[g] = cfg_r.type_sel[g] ? sum_term[g] : cell_r[g];
         assign PIN_O[g] = cfg_r.pol_sel[g] ? out_val[g] : ~out_val[g];
         assign PIN_OE_N[g] = ~OE_TERM[g];
         // pin feedback for combinatorial cells, or registered with the extra bit set
         assign FEEDBACK[g] = (cfg_r.type_sel[g] || (variant_r && cfg_r.fb_sel[g])) ?
            PIN_I[g] : cell_r[g];
         // a combinatorial cell always hands the pin level back to the array
         AST_FB_COMB: assert property (@(posedge CLK_SYS) disable iff (RST)
            cfg_r.type_sel[g] |-> FEEDBACK[g] == PIN_I[g]) else $error("combinatorial feedback wrong");
      end
   endgenerate

   // dedicated inputs and every pin reach the array
   assign ARRAY_IN = {PIN_I, DED_IN};

   // =====================================================
   // output registers: async reset term is a constant clear, reset wins
   // preload beats preset so a tester's chosen state is not lost on the same edge
   always_ff @(posedge CLK_SYS or posedge ARESET_TERM) begin
      if (ARESET_TERM) begin
         cell_r <= macrocell_pkg::CELL_RST;
      end else if (RST) begin
         cell_r <= macrocell_pkg::CELL_RST;
      end else if (preload_req_r) begin
         cell_r <= preload_val_r;
      end else if (PRESET_TERM) begin
         cell_r <= {NCELL{1'b1}};
      end else begin
         cell_r <= sum_term;
      end
   end

   // sticky flag so software can see an async clear happened
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         areset_seen_r <= 1'b0;
      end else if (ARESET_TERM) begin
         areset_seen_r <= 1'b1;
      end
   end

   // =====================================================
   // axi write channel: address and data taken in either order
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_fire;
   logic wr_ok;
   // a half parks in its holding register until its partner arrives
   assign S_AXI_AWREADY = ~aw_held_r & ~S_AXI_BVALID;
   assign S_AXI_WREADY = ~w_held_r & ~S_AXI_BVALID;
   assign wr_fire = aw_held_r & w_held_r & ~S_AXI_BVALID;
   assign wr_ok = (aw_addr_r <= macrocell_pkg::ADDR_PRELOAD) && (aw_addr_r[1:0] == 2'h0);

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= S_AXI_AWADDR;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_held_r <= 1'b1;
         w_data_r <= S_AXI_WDATA;
         w_strb_r <= S_AXI_WSTRB;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= macrocell_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= wr_ok ? macrocell_pkg::RESP_OKAY : macrocell_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // config writes; low two lanes carry the 10-bit fields
   function automatic logic [9:0] merge10(input logic [9:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [9:0] m;
      m = old;
      if (s[0]) begin
         m[7:0] = d[7:0];
      end
      if (s[1]) begin
         m[9:8] = d[9:8];
      end
      merge10 = m;
   endfunction : merge10

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cfg_r <= '{type_sel: macrocell_pkg::CFG_RST, pol_sel: macrocell_pkg::CFG_RST,
                    fb_sel: macrocell_pkg::CFG_RST};
         variant_r <= 1'b0;
      end else if (wr_fire && !secure_r) begin
         // a secured part also freezes its pattern, the fuse is blown
         case (aw_addr_r)
            macrocell_pkg::ADDR_CFG_TYPE: cfg_r.type_sel <= merge10(cfg_r.type_sel, w_data_r, w_strb_r);
            macrocell_pkg::ADDR_CFG_POL: cfg_r.pol_sel <= merge10(cfg_r.pol_sel, w_data_r, w_strb_r);
            macrocell_pkg::ADDR_CFG_FB: cfg_r.fb_sel <= merge10(cfg_r.fb_sel, w_data_r, w_strb_r);
            macrocell_pkg::ADDR_CTRL: begin
               if (w_strb_r[0]) begin
                  variant_r <= w_data_r[macrocell_pkg::CTRL_VARIANT_BIT];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // security is one-way: only reset clears it
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         secure_r <= 1'b0;
      end else if (wr_fire && aw_addr_r == macrocell_pkg::ADDR_CTRL && w_strb_r[0] &&
                   w_data_r[macrocell_pkg::CTRL_SECURE_BIT]) begin
         secure_r <= 1'b1;
      end
   end

   // preload request lasts one cycle, value then held by the register
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         preload_req_r <= 1'b0;
         preload_val_r <= macrocell_pkg::CELL_RST;
      end else begin
         preload_req_r <= wr_fire && aw_addr_r == macrocell_pkg::ADDR_PRELOAD;
         if (wr_fire && aw_addr_r == macrocell_pkg::ADDR_PRELOAD) begin
            preload_val_r <= w_data_r[NCELL-1:0];
         end
      end
   end

   // =====================================================
   // axi read channel
   macrocell_pkg::rd_state_t rd_state_r;
   logic [31:0] rd_word;
   logic rd_err;
   assign S_AXI_ARREADY = (rd_state_r == macrocell_pkg::RD_IDLE);
   assign S_AXI_RVALID = (rd_state_r == macrocell_pkg::RD_RESP);

   // config registers read as zero with an error once secured
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_err = 1'b0;
      case (S_AXI_ARADDR)
         macrocell_pkg::ADDR_CFG_TYPE: begin
            rd_word = secure_r ? 32'h0000_0000 : {22'h000000, cfg_r.type_sel};
            rd_err = secure_r;
         end
         macrocell_pkg::ADDR_CFG_POL: begin
            rd_word = secure_r ? 32'h0000_0000 : {22'h000000, cfg_r.pol_sel};
            rd_err = secure_r;
         end
         macrocell_pkg::ADDR_CFG_FB: begin
            rd_word = secure_r ? 32'h0000_0000 : {22'h000000, cfg_r.fb_sel};
            rd_err = secure_r;
         end
         // the variant bit is part of the pattern, so it reads as zero once secured
         macrocell_pkg::ADDR_CTRL: rd_word = {30'h00000000, variant_r & ~secure_r, secure_r};
         macrocell_pkg::ADDR_PRELOAD: rd_word = {22'h000000, preload_val_r};
         macrocell_pkg::ADDR_STATUS: rd_word = {21'h000000, areset_seen_r, cell_r};
         macrocell_pkg::ADDR_READBACK: rd_word = {22'h000000, PIN_O};
         default: rd_err = 1'b1;
      endcase
   end

   // data captured with the address, so it stands unchanged while rvalid waits
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rd_state_r <= macrocell_pkg::RD_IDLE;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= macrocell_pkg::RESP_OKAY;
      end else begin
         case (rd_state_r)
            macrocell_pkg::RD_IDLE: begin
               if (S_AXI_ARVALID) begin
                  rd_state_r <= macrocell_pkg::RD_RESP;
                  S_AXI_RDATA <= rd_word;
                  S_AXI_RRESP <= rd_err ? macrocell_pkg::RESP_SLVERR : macrocell_pkg::RESP_OKAY;
               end
            end
            macrocell_pkg::RD_RESP: begin
               if (S_AXI_RREADY) begin
                  rd_state_r <= macrocell_pkg::RD_IDLE;
               end
            end
            default: rd_state_r <= macrocell_pkg::RD_IDLE;
         endcase
      end
   end

   // =====================================================
   // checks
   // pin level against polarity, driver enable against its term
   AST_POL_PIN: assert property (@(posedge CLK_SYS) disable iff (RST)
      PIN_O == (out_val ^ ~cfg_r.pol_sel)) else $error("pin polarity wrong");
   AST_OE: assert property (@(posedge CLK_SYS) disable iff (RST)
      PIN_OE_N == ~OE_TERM) else $error("driver enable wrong");
   // cell 0 seen from the pin in the two corners the tests walk through
   AST_COMB_HIGH: assert property (@(posedge CLK_SYS) disable iff (RST)
      (cfg_r.type_sel[0] && cfg_r.pol_sel[0]) |-> PIN_O[0] == sum_term[0])
      else $error("combinatorial pin wrong");
   AST_REG_LOW: assert property (@(posedge CLK_SYS) disable iff (RST)
      (!cfg_r.type_sel[0] && !cfg_r.pol_sel[0]) |-> PIN_O[0] == !cell_r[0])
      else $error("registered pin wrong");
   // register next state, each source below the async clear in priority
   AST_REG_NEXT: assert property (@(posedge CLK_SYS) disable iff (RST || ARESET_TERM)
      (!preload_req_r && !PRESET_TERM && !$past(ARESET_TERM)) |=> cell_r == $past(sum_term))
      else $error("register did not follow sum");
   AST_PRESET: assert property (@(posedge CLK_SYS) disable iff (RST || ARESET_TERM)
      (PRESET_TERM && !preload_req_r) |=> cell_r == {NCELL{1'b1}}) else $error("preset missed");
   AST_ARESET: assert property (@(posedge CLK_SYS) ARESET_TERM |-> cell_r == '0)
      else $error("async clear missed");
   AST_ARESET_SEEN: assert property (@(posedge CLK_SYS) disable iff (RST)
      ARESET_TERM |=> areset_seen_r) else $error("async clear not recorded");
   AST_RESET_LOW: assert property (@(posedge CLK_SYS) RST |=> cell_r == '0) else $error("reset not low");
   AST_PRELOAD: assert property (@(posedge CLK_SYS) disable iff (RST || ARESET_TERM)
      preload_req_r |=> cell_r == $past(preload_val_r)) else $error("preload not taken");
   // feedback source of cell 0; the other cells share the same mux
   AST_FB_REG: assert property (@(posedge CLK_SYS) disable iff (RST)
      (!cfg_r.type_sel[0] && !(variant_r && cfg_r.fb_sel[0])) |-> FEEDBACK[0] == cell_r[0])
      else $error("feedback source wrong");
   AST_FB_PIN: assert property (@(posedge CLK_SYS) disable iff (RST)
      (variant_r && cfg_r.fb_sel[0]) |-> FEEDBACK[0] == PIN_I[0]) else $error("pin feedback wrong");
   // secured: pattern reads refused, pattern writes ignored, only reset undoes it
   AST_SECURE: assert property (@(posedge CLK_SYS) disable iff (RST)
      (secure_r && S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == macrocell_pkg::ADDR_CFG_TYPE)
      |=> (S_AXI_RVALID && S_AXI_RDATA == 32'h0000_0000 && S_AXI_RRESP == macrocell_pkg::RESP_SLVERR))
      else $error("secured readout leaked");
   AST_SECURE_OTHER: assert property (@(posedge CLK_SYS) disable iff (RST)
      (secure_r && S_AXI_ARVALID && S_AXI_ARREADY &&
      (S_AXI_ARADDR == macrocell_pkg::ADDR_CFG_POL || S_AXI_ARADDR == macrocell_pkg::ADDR_CFG_FB))
      |=> (S_AXI_RVALID && S_AXI_RDATA == 32'h0000_0000 && S_AXI_RRESP == macrocell_pkg::RESP_SLVERR))
      else $error("secured pattern read leaked");
   AST_SECURE_KEEP: assert property (@(posedge CLK_SYS) disable iff (RST)
      secure_r |=> secure_r) else $error("security dropped");
   AST_CFG_FROZEN: assert property (@(posedge CLK_SYS) disable iff (RST)
      secure_r |=> $stable(cfg_r)) else $error("secured pattern changed");
   // main scenarios
   COV_PRELOAD: cover property (@(posedge CLK_SYS) preload_req_r);
   COV_SECURE_READ: cover property (@(posedge CLK_SYS) secure_r && S_AXI_RVALID);
   COV_PRESET: cover property (@(posedge CLK_SYS) PRESET_TERM && !RST);
   COV_ASYNC_CLEAR: cover property (@(posedge CLK_SYS) ARESET_TERM && !RST);
   COV_PIN_FB: cover property (@(posedge CLK_SYS) variant_r && !cfg_r.type_sel[0] && cfg_r.fb_sel[0]);
endmodule : output_macrocell

/* File: sim/board_model.sv */
// board-side model: resolves each io pin from device and board drive
`timescale 1ns/1ps
module board_model (
   input wire logic [9:0] pin_o, // device drive value
   input wire logic [9:0] pin_oe_n, // device enable, low drives
   input wire logic [9:0] ext_val, // board drive value
   input wire logic [9:0] ext_en, // board drives when high
   output logic [9:0] pin_i // resolved pin level
);
   // =====================================================
   // pull-up when nobody drives; contention is unknown, never a kind guess
   always_comb begin
      for (int k = 0; k < 10; k++) begin
         case ({!pin_oe_n[k], ext_en[k]})
            2'h2: pin_i[k] = pin_o[k];
            2'h1: pin_i[k] = ext_val[k];
            2'h0: pin_i[k] = 1'h1;
            default: pin_i[k] = 1'hx;
         endcase
      end
   end
endmodule : board_model

/* File: sim/tb_top.sv */
// self-checking bench for the output macrocell stage
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top;
   // =====================================================
   // stimulus and observed signals
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [159:0] pterm = 160'h0;
   logic [9:0] oe_term = 10'h3ff;
   logic [9:0] ext_en = 10'h000;
   logic preset_t = 1'h0;
   logic areset_t = 1'h0;
   logic [9:0] pin_i, pin_o, pin_oe_n, feedback;
   logic [21:0] array_in;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_v;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, seen;
   logic [1:0] bresp, rresp, rs;
   int fails = 0;
   int cmp_count = 0;
   int n_terms[10] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
   logic [7:0] adr[7] = '{macrocell_pkg::ADDR_CFG_TYPE, macrocell_pkg::ADDR_CFG_POL,
      macrocell_pkg::ADDR_CFG_FB, macrocell_pkg::ADDR_CTRL, macrocell_pkg::ADDR_PRELOAD,
      macrocell_pkg::ADDR_STATUS, macrocell_pkg::ADDR_READBACK};

   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end

   output_macrocell output_macrocell_inst (.CLK_SYS(clk), .RST(rst), .DED_IN(12'ha5c), .PTERM(pterm),
      .OE_TERM(oe_term), .PRESET_TERM(preset_t), .ARESET_TERM(areset_t), .PIN_I(pin_i), .PIN_O(pin_o),
      .PIN_OE_N(pin_oe_n), .ARRAY_IN(array_in), .FEEDBACK(feedback), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   board_model board_model_inst (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_val(10'h155),
      .ext_en(ext_en), .pin_i(pin_i));

   // =====================================================
   // bus tasks: each channel held until its own ready edge
   // no cycle count assumed: only the watchdog ends a wait for an answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask : rd

   task automatic summarize();
      $display("checks %0d errors %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   // watchdog: whole sequence needs well under this
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      summarize();
   end

   // =====================================================
   // test sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         rd(adr[i], rd_v, rs);
         `CHK("reset value", 32'h0, rd_v)
      end
      `CHK("reset pins", 10'h3ff, pin_o)
      // combinatorial, active high: last used term counts, next one does not
      wr(adr[0], 32'h3ff, rs);
      wr(adr[1], 32'h3ff, rs);
      for (int g = 0; g < 10; g++) begin
         @(posedge clk);
         pterm <= 160'h1 << (g * 16 + n_terms[g] - 1);
         @(negedge clk);
         `CHK("last term", 10'h1 << g, pin_o)
         @(posedge clk);
         pterm <= (n_terms[g] < 16) ? 160'h1 << (g * 16 + n_terms[g]) : 160'h0;
         @(negedge clk);
         `CHK("unused term", 10'h0, pin_o)
      end
      wr(adr[1], 32'h0, rs);
      `CHK("active low", 10'h3ff, pin_o)
      // pins turned round to inputs, board drives them
      @(posedge clk);
      oe_term <= 10'h000;
      ext_en <= 10'h3ff;
      @(negedge clk);
      `CHK("oe off", 10'h3ff, pin_oe_n)
      `CHK("array in", {10'h155, 12'ha5c}, array_in)
      `CHK("comb fb", 10'h155, feedback)
      wr(adr[0], 32'h0, rs);
      `CHK("reg fb", 10'h0, feedback)
      wr(adr[2], 32'h01f, rs);
      `CHK("fb base", 10'h0, feedback)
      wr(adr[3], 32'h2, rs);
      `CHK("fb variant", 10'h015, feedback)
      @(posedge clk);
      oe_term <= 10'h3ff;
      ext_en <= 10'h000;
      // registered timing, shared preset and async clear
      wr(adr[1], 32'h3ff, rs);
      pterm <= 160'h1;
      @(negedge clk);
      `CHK("reg before edge", 10'h0, pin_o)
      @(negedge clk);
      `CHK("reg after edge", 10'h1, pin_o)
      @(posedge clk);
      pterm <= 160'h0;
      preset_t <= 1'h1;
      @(negedge clk);
      `CHK("preset wait", 10'h1, pin_o)
      @(negedge clk);
      `CHK("preset", 10'h3ff, pin_o)
      @(posedge clk);
      pterm <= {160{1'h1}};
      preset_t <= 1'h0;
      areset_t <= 1'h1;
      #1;
      `CHK("async clear", 10'h0, pin_o)
      repeat (2) @(negedge clk);
      `CHK("clear holds", 10'h0, pin_o)
      @(posedge clk);
      areset_t <= 1'h0;
      pterm <= 160'h0;
      // preload: sums are zero, so the value shows for one cycle only
      wr(adr[4], 32'h2a5, rs);
      seen = 1'h0;
      repeat (4) begin
         @(negedge clk);
         if (pin_o === 10'h2a5) seen = 1'h1;
      end
      `CHK("preload", 1'h1, seen)
      rd(adr[4], rd_v, rs);
      `CHK("preload value", 32'h2a5, rd_v)
      // sums are zero again; the async clear seen earlier stays recorded
      rd(adr[5], rd_v, rs);
      `CHK("status", 32'h400, rd_v)
      // security, then refused places
      wr(adr[1], 32'h0, rs);
      wr(adr[3], 32'h1, rs);
      rd(adr[0], rd_v, rs);
      `CHK("secured data", 32'h0, rd_v)
      `CHK("secured resp", macrocell_pkg::RESP_SLVERR, rs)
      rd(adr[1], rd_v, rs);
      `CHK("secured pol data", 32'h0, rd_v)
      `CHK("secured pol resp", macrocell_pkg::RESP_SLVERR, rs)
      wr(adr[1], 32'h3ff, rs);
      rd(adr[6], rd_v, rs);
      `CHK("pins kept", 32'h3ff, rd_v)
      rd(8'h1c, rd_v, rs);
      `CHK("unmapped", macrocell_pkg::RESP_SLVERR, rs)
      wr(adr[5], 32'h1, rs);
      `CHK("ro write", macrocell_pkg::RESP_SLVERR, rs)
      summarize();
   end
endmodule : tb_top
